// ===== hdl/dma_irq_defs.svh
// register offsets, field positions, reset values and timing counts
// assumes a 32-bit byte-addressed register slave; included by bare name
`ifndef DMA_IRQ_DEFS_SVH
`define DMA_IRQ_DEFS_SVH

// ----------------------------------------------------------------------
// register map (byte addresses)
// ----------------------------------------------------------------------
`define CH0_BASE      12'h000
`define CH1_BASE      12'h030
`define CTRL_OFF      12'h000
`define STAT_OFF      12'h004
`define CDP_OFF       12'h008

// ----------------------------------------------------------------------
// chan_control_reg fields
// ----------------------------------------------------------------------
`define CTL_RUN       0
`define CTL_CEN       12
`define CTL_DEN       13
`define CTL_EEN       14
`define CTL_THR_LSB   16
`define CTL_DLY_LSB   24
`define THR_RST       8'h01
`define DLY_RST       8'h00

// ----------------------------------------------------------------------
// chan_status_reg fields
// ----------------------------------------------------------------------
`define ST_HALT       0
`define ST_ERR_LSB    4
`define ST_CFLG       12
`define ST_DFLG       13
`define ST_EFLG       14
`define ST_TCNT_LSB   16
`define ST_DCNT_LSB   24

// ----------------------------------------------------------------------
// timing: delay timer tick period in ns at a 10 ns clock
// ----------------------------------------------------------------------
`define CLK_PERIOD_NS 10
`define DLY_TICK_NS   10
`define DLY_TICK_CYC  ((`DLY_TICK_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// ===== hdl/dma_irq_pkg.sv
// state types of the channel interrupt and error unit
// assumes nothing beyond the standard language
package dma_irq_pkg;

   // ----------------------------------------------------------------------
   // per-channel state
   // ----------------------------------------------------------------------
   typedef struct packed {
      logic        run;      // run_stop_bit
      logic        halted;
      logic        cen;      // complete_irq_enable
      logic        den;      // delay irq enable
      logic        een;      // error irq enable
      logic [7:0]  thresh;   // coalesce_count_field
      logic [7:0]  dly_to;   // delay_timeout_field
      logic [7:0]  tcnt;     // live threshold counter
      logic [7:0]  dcnt;     // delay timer
      logic        dly_run;
      logic        cflag;    // complete_irq_flag
      logic        dflag;    // delay irq flag
      logic        eflag;    // error irq flag
      logic [5:0]  errs;     // {sdec,sslv,sint,ddec,dslv,dint}
      logic        logged;
      logic [31:0] curdesc;  // current_desc_pointer
      logic        irq;
   } chan_t;

   // ----------------------------------------------------------------------
   // whole-block state
   // ----------------------------------------------------------------------
   typedef struct packed {
      chan_t [1:0] ch;
      logic [11:0] addr;
      logic        wr_pend;
      logic        rd_pend;
      logic        hready;
      logic [31:0] hrdata;
      logic [15:0] tick;
   } state_t;

endpackage

// ===== hdl/dma_channel_irq_error_unit.sv
// interrupt coalescing, delay timer and error handling for both channels
// assumes engine event strobes on hclk, AHB-Lite single word transfers
//
// Functional notes
// - chain mode irq: threshold, delay or error
// - simple mode irq on transfer complete
// - each completion event decrements threshold counter
// - counter zero sets flag, irq if enabled
// - threshold interrupt reloads counter from field
// - live counter readable in status register
// - coalesce field resets to one
// - delay event or field write reloads counter
// - zero delay timeout disables delay timer
// - end of packet starts delay timer
// - start of packet resets delay timer
// - delay event zeroes timer, waits flag clear
// - error clears run, halts after idle
// - one errored descriptor address is logged
// - zero length descriptor gives data internal error
// - write channel underflow gives internal error
// - data slave and decode errors flagged
// - stale descriptor gives descriptor internal error
// - descriptor fetch/update slave, decode errors
// - descriptor errors kept only in status
// - descriptor errors outrank zero length, others
`timescale 1ns/10ps
`include "dma_irq_defs.svh"

module dma_channel_irq_error_unit #(
   parameter bit          DESC_CHAIN_OPTION    = 1'b1,
   parameter bit          STATUS_LENGTH_OPTION = 1'b1,
   parameter int unsigned DLY_TICK_DIV         = `DLY_TICK_CYC
) (
   // clock and reset
   input  wire logic        hclk,
   input  wire logic        hresetn,
   // AHB-Lite slave
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic             hresp,
   output logic [31:0]      hrdata,
   // engine events, index 0 read channel, 1 write channel
   input  wire logic [1:0]  eop_event,
   input  wire logic [1:0]  sop_event,
   input  wire logic [1:0]  transfer_done,
   input  wire logic [1:0]  engine_idle,
   // error reports
   input  wire logic [1:0]  zero_len_error,
   input  wire logic        stream_underflow,
   input  wire logic [1:0]  data_slverr,
   input  wire logic [1:0]  data_decerr,
   input  wire logic [1:0]  desc_stale,
   input  wire logic [1:0]  desc_slverr,
   input  wire logic [1:0]  desc_decerr,
   input  wire logic [31:0] desc_err_addr_rd,
   input  wire logic [31:0] desc_err_addr_wr,
   input  wire logic [31:0] data_err_addr_rd,
   input  wire logic [31:0] data_err_addr_wr,
   // channel outputs
   output logic             read_chan_irq_out,
   output logic             write_chan_irq_out,
   output logic [1:0]       chan_run,
   output logic [1:0]       chan_halted
);

   // ----------------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------------
   // register address of channel i at offset off
   function automatic logic is_reg(logic [11:0] a, int i, logic [11:0] off);
      logic [11:0] base;
      base = (i == 1) ? `CH1_BASE : `CH0_BASE;
      return a == (base + off);
   endfunction

   // read value of one register of one channel; unmapped reads as zero
   function automatic logic [31:0] reg_read(dma_irq_pkg::chan_t c, logic [11:0] a,
                                            int i);
      logic [31:0] v;
      v = 32'h0000_0000;
      if (is_reg(a, i, `CTRL_OFF)) begin
         v[`CTL_RUN]                   = c.run;
         v[`CTL_CEN]                   = c.cen;
         v[`CTL_DEN]                   = c.den;
         v[`CTL_EEN]                   = c.een;
         v[`CTL_THR_LSB +: 8]          = c.thresh;
         v[`CTL_DLY_LSB +: 8]          = c.dly_to;
      end else if (is_reg(a, i, `STAT_OFF)) begin
         v[`ST_HALT]                   = c.halted;
         v[`ST_ERR_LSB +: 3]           = c.errs[2:0];
         v[`ST_ERR_LSB + 4 +: 3]       = c.errs[5:3];
         v[`ST_CFLG]                   = c.cflag;
         v[`ST_DFLG]                   = c.dflag;
         v[`ST_EFLG]                   = c.eflag;
         v[`ST_TCNT_LSB +: 8]          = c.tcnt;
         v[`ST_DCNT_LSB +: 8]          = c.dcnt;
      end else if (is_reg(a, i, `CDP_OFF)) begin
         v = c.curdesc;
      end
      return v;
   endfunction

   // ----------------------------------------------------------------------
   // state
   // ----------------------------------------------------------------------
   dma_irq_pkg::state_t q;
   dma_irq_pkg::state_t next_q;

   logic       tick;
   logic [5:0] err_now [2];

   assign tick = (q.tick == 16'(DLY_TICK_DIV - 1));

   // error sources per channel, ordered as the status field
   always_comb begin
      for (int i = 0; i < 2; i++) begin
         err_now[i][0] = DESC_CHAIN_OPTION & (zero_len_error[i]
                         | ((i == 1) & STATUS_LENGTH_OPTION & stream_underflow));
         err_now[i][1] = data_slverr[i];
         err_now[i][2] = data_decerr[i];
         err_now[i][3] = DESC_CHAIN_OPTION & desc_stale[i];
         err_now[i][4] = DESC_CHAIN_OPTION & desc_slverr[i];
         err_now[i][5] = DESC_CHAIN_OPTION & desc_decerr[i];
      end
   end

   // ----------------------------------------------------------------------
   // next-state logic
   // ----------------------------------------------------------------------
   // writes land before events, except the counter reload, so that a hardware set always beats a clear
   always_comb begin
      logic        wr_ctl;
      logic        wr_st;
      logic        fire;
      logic [31:0] w;
      next_q = q;
      wr_ctl = 1'b0;
      wr_st  = 1'b0;
      fire   = 1'b0;
      w      = hwdata;

      // tick divider for the delay timer
      next_q.tick = tick ? 16'h0000 : q.tick + 16'h0001;

      // bus: a read takes one wait state so it always sees prior writes
      next_q.wr_pend = 1'b0;
      if (q.rd_pend) begin
         next_q.hrdata  = reg_read(q.ch[0], q.addr, 0) | reg_read(q.ch[1], q.addr, 1);
         next_q.hready  = 1'b1;
         next_q.rd_pend = 1'b0;
      end
      if (hsel && hready && htrans[1]) begin
         next_q.addr    = haddr[11:0];
         next_q.wr_pend = hwrite;
         next_q.rd_pend = !hwrite;
         next_q.hready  = hwrite;
      end

      for (int i = 0; i < 2; i++) begin
         wr_ctl = q.wr_pend && is_reg(q.addr, i, `CTRL_OFF);
         wr_st  = q.wr_pend && is_reg(q.addr, i, `STAT_OFF);
         fire   = 1'b0;

         // software control write; run cannot restart after an error
         if (wr_ctl) begin
            next_q.ch[i].run    = w[`CTL_RUN] && (q.ch[i].errs == 6'h00);
            next_q.ch[i].cen    = w[`CTL_CEN];
            next_q.ch[i].den    = w[`CTL_DEN];
            next_q.ch[i].een    = w[`CTL_EEN];
            next_q.ch[i].thresh = w[`CTL_THR_LSB +: 8];
            next_q.ch[i].dly_to = w[`CTL_DLY_LSB +: 8];
         end
         // flags clear by writing one
         if (wr_st) begin
            if (w[`ST_CFLG]) next_q.ch[i].cflag = 1'b0;
            if (w[`ST_DFLG]) next_q.ch[i].dflag = 1'b0;
            if (w[`ST_EFLG]) next_q.ch[i].eflag = 1'b0;
         end

         if (DESC_CHAIN_OPTION) begin
            // threshold counter
            if (eop_event[i]) begin
               if (q.ch[i].tcnt <= 8'h01) begin
                  next_q.ch[i].cflag = 1'b1;
                  next_q.ch[i].tcnt  = q.ch[i].thresh;
               end else begin
                  next_q.ch[i].tcnt = q.ch[i].tcnt - 8'h01;
               end
            end
            // delay timer, stopped while its flag is pending
            if (q.ch[i].dly_to == 8'h00) begin
               next_q.ch[i].dcnt    = 8'h00;
               next_q.ch[i].dly_run = 1'b0;
            end else if (!q.ch[i].dflag) begin
               if (sop_event[i]) begin
                  next_q.ch[i].dcnt    = 8'h00;
                  next_q.ch[i].dly_run = 1'b0;
               end else if (eop_event[i]) begin
                  next_q.ch[i].dly_run = 1'b1;
               end else if (q.ch[i].dly_run && tick) begin
                  if (q.ch[i].dcnt + 8'h01 >= q.ch[i].dly_to) begin
                     fire = 1'b1;
                  end else begin
                     next_q.ch[i].dcnt = q.ch[i].dcnt + 8'h01;
                  end
               end
            end
            if (fire) begin
               next_q.ch[i].dflag   = 1'b1;
               next_q.ch[i].dcnt    = 8'h00;
               next_q.ch[i].dly_run = 1'b0;
               next_q.ch[i].tcnt    = q.ch[i].thresh;
            end
         end else if (transfer_done[i]) begin
            next_q.ch[i].cflag = 1'b1;
         end
         // a write of the field reloads the counter last
         if (wr_ctl) begin
            next_q.ch[i].tcnt = w[`CTL_THR_LSB +: 8];
         end

         // errors: sticky in status only, stop the channel
         if (err_now[i] != 6'h00) begin
            next_q.ch[i].errs  = q.ch[i].errs | err_now[i];
            next_q.ch[i].eflag = 1'b1;
            next_q.ch[i].run   = 1'b0;
            if (DESC_CHAIN_OPTION && !q.ch[i].logged) begin
               next_q.ch[i].logged = 1'b1;
               // descriptor-side errors rank above data-side ones
               if (err_now[i][5:3] != 3'b000) begin
                  next_q.ch[i].curdesc = (i == 1) ? desc_err_addr_wr : desc_err_addr_rd;
               end else begin
                  next_q.ch[i].curdesc = (i == 1) ? data_err_addr_wr : data_err_addr_rd;
               end
            end
         end
         // halted only once stopped and every bus transaction is done
         next_q.ch[i].halted = !next_q.ch[i].run && engine_idle[i];

         // interrupt output
         if (DESC_CHAIN_OPTION) begin
            next_q.ch[i].irq = (next_q.ch[i].cflag && next_q.ch[i].cen)
                             || (next_q.ch[i].dflag && next_q.ch[i].den)
                             || (next_q.ch[i].eflag && next_q.ch[i].een);
         end else begin
            next_q.ch[i].irq = next_q.ch[i].cflag && next_q.ch[i].cen;
         end
      end
   end

   // ----------------------------------------------------------------------
   // state register
   // ----------------------------------------------------------------------
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         q        <= '0;
         q.hready <= 1'b1;
         for (int i = 0; i < 2; i++) begin
            q.ch[i].halted <= 1'b1;
            q.ch[i].thresh <= `THR_RST;
            q.ch[i].tcnt   <= `THR_RST;
            q.ch[i].dly_to <= `DLY_RST;
         end
      end else begin
         q <= next_q;
      end
   end

   // outputs straight from the state register, hresp tied low
   assign hreadyout          = q.hready;
   assign hresp              = 1'b0;
   assign hrdata             = q.hrdata;
   assign read_chan_irq_out  = q.ch[0].irq;
   assign write_chan_irq_out = q.ch[1].irq;
   assign chan_run           = {q.ch[1].run, q.ch[0].run};
   assign chan_halted        = {q.ch[1].halted, q.ch[0].halted};

   // ----------------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------------
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   logic [3:0] hsize_unused;
   assign hsize_unused = {1'b0, hsize};

   chain_irq_a: assert property (DESC_CHAIN_OPTION && q.ch[0].cflag && q.ch[0].cen
      |-> read_chan_irq_out) else $error("irq low with complete flag enabled");
   simple_irq_a: assert property (!DESC_CHAIN_OPTION && transfer_done[1]
      && q.ch[1].cen |=> write_chan_irq_out) else $error("simple irq missing");
   thr_dec_a: assert property (DESC_CHAIN_OPTION && eop_event[0] && !q.wr_pend
      && q.ch[0].tcnt > 8'h01 && !q.ch[0].dly_run
      |=> q.ch[0].tcnt == $past(q.ch[0].tcnt) - 8'h01) else $error("no decrement");
   thr_reload_a: assert property (DESC_CHAIN_OPTION && eop_event[0] && !q.wr_pend
      && q.ch[0].tcnt == 8'h01 |=> q.ch[0].cflag && q.ch[0].tcnt == $past(q.ch[0].thresh))
      else $error("threshold not reloaded");
   stat_view_a: assert property (q.rd_pend && q.addr == `CH0_BASE + `STAT_OFF
      |=> hreadyout && hrdata[`ST_TCNT_LSB +: 8] == $past(q.ch[0].tcnt))
      else $error("status count mismatch");
   dly_off_a: assert property (q.ch[1].dly_to == 8'h00 |=> q.ch[1].dcnt == 8'h00
      || $past(q.wr_pend)) else $error("delay timer ran while disabled");
   dly_hold_a: assert property (q.ch[1].dflag && $past(q.ch[1].dflag)
      |-> q.ch[1].dcnt == 8'h00) else $error("delay timer ran with flag set");
   err_stop_a: assert property (err_now[0] != 6'h00
      |=> !chan_run[0] ##1 !chan_run[0]) else $error("run not cleared on error");
   halt_idle_a: assert property ($rose(chan_halted[1]) |-> $past(engine_idle[1]))
      else $error("halted before idle");
   underflow_a: assert property (DESC_CHAIN_OPTION && STATUS_LENGTH_OPTION
      && stream_underflow |=> q.ch[1].errs[0]) else $error("underflow not flagged");

   chain_irq_c: cover property (DESC_CHAIN_OPTION && $rose(read_chan_irq_out));
   delay_fire_c: cover property ($rose(q.ch[1].dflag));
   halt_c: cover property (q.ch[0].errs != 6'h00 ##[1:20] chan_halted[0]);

endmodule // dma_channel_irq_error_unit

// ===== dv/irq_service_model.sv
// service model of the processor side: counts interrupts raised per channel
// assumes registered, active-high interrupt levels on hclk
`timescale 1ns/10ps

module irq_service_model (
   // clock and reset
   input  wire logic hclk,
   input  wire logic hresetn,
   // interrupt lines from the unit
   input  wire logic irq_rd,
   input  wire logic irq_wr,
   // interrupts seen since the last reset
   output int        rd_seen,
   output int        wr_seen
);
   logic prev_rd;
   logic prev_wr;

   // count rising edges only: a line left high until serviced counts once
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         prev_rd <= 1'b0;
         prev_wr <= 1'b0;
         rd_seen <= 0;
         wr_seen <= 0;
      end else begin
         prev_rd <= irq_rd;
         prev_wr <= irq_wr;
         rd_seen <= rd_seen + int'(irq_rd & ~prev_rd);
         wr_seen <= wr_seen + int'(irq_wr & ~prev_wr);
      end
   end
endmodule // irq_service_model

// ===== dv/dma_channel_irq_error_unit_tb_top.sv
// self-checking bench of the channel interrupt and error unit
// assumes the design and package under hdl/ and the service model beside it
`timescale 1ns/10ps
`include "dma_irq_defs.svh"

module dma_channel_irq_error_unit_tb_top;
   // ---------------------------------------------------------------
   // signals
   // ---------------------------------------------------------------
   logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, stream_underflow;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [1:0]  htrans, eop_event, sop_event, transfer_done, engine_idle;
   logic [1:0]  zero_len_error, data_slverr, data_decerr, desc_stale, desc_slverr;
   logic [1:0]  desc_decerr, chan_run, chan_halted;
   logic        read_chan_irq_out, write_chan_irq_out;
   int          failures, samples_checked, rd_seen, wr_seen, c;
   // error kinds, channel, expected error bits; kind 10 is two errors at once
   int          kinds [8] = '{3, 4, 5, 6, 7, 8, 9, 10};
   int          chans [8] = '{0, 1, 1, 0, 1, 0, 1, 0};
   logic [31:0] ebits [8] = '{32'h0000_0010, 32'h0000_0010, 32'h0000_0020, 32'h0000_0040,
                              32'h0000_0100, 32'h0000_0200, 32'h0000_0400, 32'h0000_0220};
   localparam logic [31:0] DESC_A = 32'h0000_1c40;
   localparam logic [31:0] DATA_A = 32'h0000_2a80;

   dma_channel_irq_error_unit uut (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .eop_event(eop_event),
      .sop_event(sop_event), .transfer_done(transfer_done), .engine_idle(engine_idle),
      .zero_len_error(zero_len_error), .stream_underflow(stream_underflow),
      .data_slverr(data_slverr), .data_decerr(data_decerr), .desc_stale(desc_stale),
      .desc_slverr(desc_slverr), .desc_decerr(desc_decerr), .desc_err_addr_rd(DESC_A),
      .desc_err_addr_wr(DESC_A), .data_err_addr_rd(DATA_A), .data_err_addr_wr(DATA_A),
      .read_chan_irq_out(read_chan_irq_out), .write_chan_irq_out(write_chan_irq_out),
      .chan_run(chan_run), .chan_halted(chan_halted));

   irq_service_model partner (
      .hclk(hclk), .hresetn(hresetn), .irq_rd(read_chan_irq_out),
      .irq_wr(write_chan_irq_out), .rd_seen(rd_seen), .wr_seen(wr_seen));

   // ---------------------------------------------------------------
   // clock, watchdog and shared tasks
   // ---------------------------------------------------------------
   initial hclk = 1'b0;
   always #5 hclk = ~hclk;

   // whole run needs well under 3000 cycles
   initial begin
      #100000;
      failures++;
      $display("ERROR %0t watchdog expired", $time);
      results();
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         failures++;
         $display("ERROR %0t got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic settle();
      @(posedge hclk);
      #1;
   endtask

   // bounded wait for hready high at a rising edge
   task automatic wait_rdy();
      int n;
      n = 0;
      @(posedge hclk);
      while (hreadyout !== 1'b1 && n < 50) begin
         @(posedge hclk);
         n++;
      end
      if (n >= 50) begin
         failures++;
         $display("ERROR %0t bus never ready", $time);
      end
   endtask

   task automatic ahb_start(input logic [11:0] a, input logic w);
      @(posedge hclk);
      hsel   <= 1'b1;
      haddr  <= {20'h0_0000, a};
      htrans <= 2'b10;
      hwrite <= w;
      wait_rdy();
      htrans <= 2'b00;
   endtask

   task automatic ahb_write(input logic [11:0] a, input logic [31:0] d);
      ahb_start(a, 1'b1);
      hwdata <= d;
      wait_rdy();
   endtask

   task automatic ahb_read(input logic [11:0] a, output logic [31:0] d);
      ahb_start(a, 1'b0);
      wait_rdy();
      d = hrdata;
   endtask

   // one-cycle engine event of kind k on channel ch
   task automatic fire(input int k, input int ch);
      logic [1:0] m;
      m = 2'b01 << ch;
      @(posedge hclk);
      case (k)
         0: eop_event <= m;
         1: sop_event <= m;
         3: zero_len_error <= m;
         4: stream_underflow <= 1'b1;
         5: data_slverr <= m;
         6: data_decerr <= m;
         7: desc_stale <= m;
         8: desc_slverr <= m;
         9: desc_decerr <= m;
         default: begin
            data_slverr <= m;
            desc_slverr <= m;
         end
      endcase
      @(posedge hclk);
      {eop_event, sop_event, zero_len_error, data_slverr, data_decerr} <= '0;
      {desc_stale, desc_slverr, desc_decerr, stream_underflow} <= '0;
   endtask

   task automatic do_reset();
      @(posedge hclk);
      hresetn <= 1'b0;
      repeat (10) @(posedge hclk);
      hresetn <= 1'b1;
   endtask

   task automatic results();
      $display("comparisons %0d mismatches %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   // ---------------------------------------------------------------
   // test sequence
   // ---------------------------------------------------------------
   initial begin
      {hresetn, hsel, haddr, htrans, hwrite, hwdata, stream_underflow} = '0;
      {eop_event, sop_event, transfer_done, zero_len_error, data_slverr} = '0;
      {data_decerr, desc_stale, desc_slverr, desc_decerr} = '0;
      engine_idle = 2'b11;
      do_reset();
      ahb_read(`CH0_BASE + `CTRL_OFF, rd);
      chk(rd, 32'h0001_0000);
      ahb_read(`CH0_BASE + `STAT_OFF, rd);
      chk(rd, 32'h0001_0001);
      ahb_read(12'h100, rd);
      chk(rd, 32'h0000_0000);
      $display("reset test done");
      // three completions per interrupt on the write channel
      ahb_write(`CH1_BASE + `CTRL_OFF, 32'h0003_1001);
      ahb_read(`CH1_BASE + `STAT_OFF, rd);
      chk(rd, 32'h0003_0000);
      repeat (2) fire(0, 1);
      settle();
      chk(write_chan_irq_out, 1'b0);
      fire(0, 1);
      settle();
      chk(write_chan_irq_out, 1'b1);
      ahb_read(`CH1_BASE + `STAT_OFF, rd);
      chk(rd, 32'h0003_1000);
      ahb_write(`CH1_BASE + `STAT_OFF, 32'h0000_1000);
      settle();
      chk(write_chan_irq_out, 1'b0);
      chk(wr_seen, 32'h0000_0001);
      $display("threshold test done");
      // delay timeout 3 on the read channel, threshold 4 never met
      ahb_write(`CH0_BASE + `CTRL_OFF, 32'h0304_3001);
      fire(0, 0);
      c = 0;
      while (read_chan_irq_out !== 1'b1 && c < 50) begin
         @(posedge hclk);
         c++;
      end
      chk(read_chan_irq_out, 1'b1);
      ahb_read(`CH0_BASE + `STAT_OFF, rd);
      chk(rd, 32'h0004_2000);
      repeat (10) @(posedge hclk);
      ahb_read(`CH0_BASE + `STAT_OFF, rd);
      chk(rd, 32'h0004_2000);
      ahb_write(`CH0_BASE + `STAT_OFF, 32'h0000_2000);
      // each start of packet restarts the timer before it can expire
      ahb_write(`CH0_BASE + `CTRL_OFF, 32'h0304_2001);
      repeat (4) begin
         fire(0, 0);
         fire(1, 0);
      end
      settle();
      chk(read_chan_irq_out, 1'b0);
      ahb_read(`CH0_BASE + `STAT_OFF, rd);
      chk(rd, 32'h0004_1000);
      // zero timeout disables the timer
      ahb_write(`CH0_BASE + `CTRL_OFF, 32'h0004_2001);
      fire(0, 0);
      repeat (20) @(posedge hclk);
      ahb_read(`CH0_BASE + `STAT_OFF, rd);
      chk(rd & 32'h0000_2000, 32'h0000_0000);
      $display("delay test done");
      // each error kind: run drops, halt waits for idle, pointer logged
      for (int i = 0; i < 8; i++) begin
         do_reset();
         c = chans[i];
         ahb_write(`CH0_BASE + 12'(c) * `CH1_BASE + `CTRL_OFF, 32'h0001_4001);
         engine_idle[c] <= 1'b0;
         settle();
         chk(chan_run[c], 1'b1);
         chk(hresp, 1'b0);
         fire(kinds[i], c);
         settle();
         chk(chan_run[c], 1'b0);
         chk(chan_halted[c], 1'b0);
         chk(c ? write_chan_irq_out : read_chan_irq_out, 1'b1);
         engine_idle[c] <= 1'b1;
         repeat (2) settle();
         chk(chan_halted[c], 1'b1);
         ahb_read(`CH0_BASE + 12'(c) * `CH1_BASE + `STAT_OFF, rd);
         chk(rd, 32'h0001_4001 | ebits[i]);
         ahb_read(`CH0_BASE + 12'(c) * `CH1_BASE + `CDP_OFF, rd);
         chk(rd, kinds[i] >= 7 ? DESC_A : DATA_A);
      end
      $display("error test done");
      results();
   end
endmodule // dma_channel_irq_error_unit_tb_top
